// file: logic/svc_pkg.sv
// package for the synthesizer vco configuration page
// assumes byte-wide register port, one core clock
package svc_pkg;
    localparam int ADDR_W = 12;
    localparam int NUM_SYN = 4;
    localparam int NUM_LOOPS = 4;
    localparam int MASK_W = 10;
    localparam int FREQ_W = 64;
    typedef logic [ADDR_W-1:0] svc_addr_t;
    typedef logic [7:0] svc_byte_t;
    typedef logic [15:0] svc_h_t;
    typedef logic [23:0] svc_m_t;
    typedef logic [FREQ_W-1:0] svc_freq_t;
    // page byte addresses (little endian within a field)
    localparam svc_addr_t ADR_MASK_LO = 12'h682;
    localparam svc_addr_t ADR_MASK_HI = 12'h683;
    localparam svc_addr_t ADR_SEMA = 12'h684;
    localparam svc_addr_t ADR_BASE = 12'h685;
    localparam svc_addr_t ADR_MULT = 12'h687;
    localparam svc_addr_t ADR_NUM = 12'h68a;
    localparam svc_addr_t ADR_DEN = 12'h68c;
    localparam svc_addr_t ADR_CTRL = 12'h693;
    // reset values
    localparam svc_h_t RST_BASE = 16'h1f40;
    localparam svc_m_t RST_MULT = 24'h017bb0;
    localparam svc_h_t RST_NUM = 16'h0001;
    localparam svc_h_t RST_DEN = 16'h0001;
    localparam svc_byte_t RST_CTRL = 8'h01;
    localparam logic [MASK_W-1:0] RST_MASK = 10'h000;
    // field positions
    localparam int SEMA_WR = 0;
    localparam int SEMA_RD = 1;
    localparam int CTRL_EN = 0;
    localparam int SEL_LO = 4;
    localparam int SEL_HI = 6;
    localparam svc_byte_t CTRL_KEEP = 8'h71;
    localparam int DIV_CYC = 66;
    typedef enum logic [1:0] {
        SVC_IDLE = 2'b00,
        SVC_WRITE = 2'b01,
        SVC_READ = 2'b10
    } svc_state_e;
endpackage

// file: logic/svc_synth_slot.sv
// one synthesizer's committed settings and its vco frequency
// assumes a load pulse from the page logic on the same clock
module svc_synth_slot
    import svc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic load,
    input wire svc_pkg::svc_h_t base_in,
    input wire svc_pkg::svc_m_t mult_in,
    input wire svc_pkg::svc_h_t num_in,
    input wire svc_pkg::svc_h_t den_in,
    input wire svc_pkg::svc_byte_t ctrl_in,
    output svc_pkg::svc_h_t base_q,
    output svc_pkg::svc_m_t mult_q,
    output svc_pkg::svc_h_t num_q,
    output svc_pkg::svc_h_t den_q,
    output svc_pkg::svc_byte_t ctrl_q,
    output logic [1:0] loop_sel,
    output logic enable,
    output svc_pkg::svc_freq_t vco_freq
);
    import svc_pkg::*;

    svc_h_t base_r, base_nxt, num_r, num_nxt, den_r, den_nxt;
    svc_h_t dsor_r, dsor_nxt;
    svc_m_t mult_r, mult_nxt;
    svc_byte_t ctrl_r, ctrl_nxt;
    svc_freq_t prod_r, prod_nxt, freq_r, freq_nxt;
    logic [2:0] sel;

    always_comb begin
        base_nxt = load ? base_in : base_r;
        mult_nxt = load ? mult_in : mult_r;
        num_nxt = load ? num_in : num_r;
        den_nxt = load ? den_in : den_r;
        ctrl_nxt = load ? ctrl_in : ctrl_r;
        prod_nxt = svc_freq_t'(base_r) * svc_freq_t'(mult_r) * svc_freq_t'(num_r); // [R1]
        // divisor follows the product stage so a fresh load never mixes old and new terms
        dsor_nxt = den_r;
        freq_nxt = (dsor_r == '0) ? prod_r : prod_r / svc_freq_t'(dsor_r); // [R1]
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            base_r <= RST_BASE;
            mult_r <= RST_MULT;
            num_r <= RST_NUM;
            den_r <= RST_DEN;
            ctrl_r <= RST_CTRL;
            prod_r <= '0;
            dsor_r <= RST_DEN;
            freq_r <= '0;
        end else begin
            base_r <= base_nxt;
            mult_r <= mult_nxt;
            num_r <= num_nxt;
            den_r <= den_nxt;
            ctrl_r <= ctrl_nxt;
            prod_r <= prod_nxt;
            dsor_r <= dsor_nxt;
            freq_r <= freq_nxt;
        end
    end

    assign sel = ctrl_r[SEL_HI:SEL_LO];
    assign base_q = base_r;
    assign mult_q = mult_r;
    assign num_q = num_r;
    assign den_q = den_r;
    assign ctrl_q = ctrl_r;
    assign loop_sel = (sel < 3'(NUM_LOOPS)) ? sel[1:0] : 2'h0; // [R7]
    assign enable = ctrl_r[CTRL_EN]; // [R9]
    assign vco_freq = freq_r;
endmodule

// file: logic/svc_page.sv
// synthesizer vco configuration page with mailbox commit
// assumes a byte register port on core_clk, read data one cycle later
//
// Function
// [R1] vco frequency is base times multiplier times numerator over denominator
// [R2] base term is 16-bit read/write, hertz, reset 0x1f40
// [R3] multiplier term is 24-bit read/write over three bytes, reset 0x017bb0
// [R4] numerator term is 16-bit read/write, reset 0x0001
// [R5] denominator term is 16-bit read/write, reset 0x0001
// [R6] control bits 6 to 4 choose the timing loop of the synthesizer
// [R7] a loop number that does not exist selects timing loop zero
// [R8] host disables, commits, then sets new select enabled and commits again
// [R9] control bit 0 enables the synthesizer; control resets to 0x01
// [R10] write request with read clear commits page to all masked synthesizers
// [R11] read request with one mask bit loads that synthesizer into page
// [R12] host picks targets with a 10-bit mask, bits 0 to 3 used
// [R13] multi-byte fields sit on consecutive bytes, least significant first
//
// Our own choice: strobed register access.
module svc_page
    import svc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire svc_pkg::svc_addr_t reg_addr,
    input wire svc_pkg::svc_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output svc_pkg::svc_byte_t reg_rdata,
    output logic [NUM_SYN-1:0] syn_enable,
    output logic [2*NUM_SYN-1:0] syn_loop_sel,
    output logic [FREQ_W*NUM_SYN-1:0] syn_vco_freq
);
    import svc_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // reset release
    logic rst_s1_r, rst_n_r;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // page registers
    svc_h_t base_r, base_nxt, num_r, num_nxt, den_r, den_nxt;
    svc_m_t mult_r, mult_nxt;
    svc_byte_t ctrl_r, ctrl_nxt, rdata_r, rdata_nxt;
    logic [MASK_W-1:0] mask_r, mask_nxt;
    logic wr_req_r, wr_req_nxt, rd_req_r, rd_req_nxt;
    svc_state_e state_r, state_nxt;
    logic [NUM_SYN-1:0] load;
    logic [NUM_SYN-1:0] rd_hit;

    svc_h_t s_base [NUM_SYN];
    svc_m_t s_mult [NUM_SYN];
    svc_h_t s_num [NUM_SYN];
    svc_h_t s_den [NUM_SYN];
    svc_byte_t s_ctrl [NUM_SYN];
    logic [1:0] s_sel [NUM_SYN];
    logic s_en [NUM_SYN];
    svc_freq_t s_freq [NUM_SYN];

    logic [NUM_SYN-1:0] en_nxt, en_r;
    logic [2*NUM_SYN-1:0] sel_nxt, sel_r;
    logic [FREQ_W*NUM_SYN-1:0] freq_nxt, freq_r;

    logic one_hot;
    assign one_hot = (mask_r != '0) && ((mask_r & (mask_r - 10'h001)) == '0);

    // a new request in the cycle the machine clears the old one wins
    logic sema_wr_set, sema_rd_set;
    assign sema_wr_set = reg_wr && (reg_addr == ADR_SEMA) && reg_wdata[SEMA_WR];
    assign sema_rd_set = reg_wr && (reg_addr == ADR_SEMA) && reg_wdata[SEMA_RD];
    assign rd_hit = mask_r[NUM_SYN-1:0];

    always_comb begin
        base_nxt = base_r;
        mult_nxt = mult_r;
        num_nxt = num_r;
        den_nxt = den_r;
        ctrl_nxt = ctrl_r;
        mask_nxt = mask_r;
        wr_req_nxt = wr_req_r;
        rd_req_nxt = rd_req_r;
        state_nxt = state_r;
        load = '0;
        if (reg_wr) begin
            case (reg_addr)
                ADR_MASK_LO: mask_nxt[7:0] = reg_wdata; // [R12]
                ADR_MASK_HI: mask_nxt[MASK_W-1:8] = reg_wdata[MASK_W-9:0]; // [R12]
                ADR_SEMA: begin
                    wr_req_nxt = reg_wdata[SEMA_WR] | wr_req_r;
                    rd_req_nxt = reg_wdata[SEMA_RD] | rd_req_r;
                end
                ADR_BASE: base_nxt[7:0] = reg_wdata; // [R2] [R13]
                ADR_BASE + 12'h001: base_nxt[15:8] = reg_wdata; // [R2] [R13]
                ADR_MULT: mult_nxt[7:0] = reg_wdata; // [R3] [R13]
                ADR_MULT + 12'h001: mult_nxt[15:8] = reg_wdata; // [R3]
                ADR_MULT + 12'h002: mult_nxt[23:16] = reg_wdata; // [R3]
                ADR_NUM: num_nxt[7:0] = reg_wdata; // [R4]
                ADR_NUM + 12'h001: num_nxt[15:8] = reg_wdata; // [R4]
                ADR_DEN: den_nxt[7:0] = reg_wdata; // [R5]
                ADR_DEN + 12'h001: den_nxt[15:8] = reg_wdata; // [R5]
                ADR_CTRL: ctrl_nxt = reg_wdata & CTRL_KEEP; // [R6] [R9]
                default: ;
            endcase
        end
        case (state_r)
            SVC_IDLE: begin
                if (rd_req_r) begin
                    state_nxt = SVC_READ;
                end else if (wr_req_r) begin
                    state_nxt = SVC_WRITE;
                end
            end
            SVC_WRITE: begin
                load = mask_r[NUM_SYN-1:0]; // [R10] [R8]
                wr_req_nxt = sema_wr_set; // [R10]
                state_nxt = SVC_IDLE;
            end
            SVC_READ: begin
                if (one_hot) begin
                    for (int i = 0; i < NUM_SYN; i++) begin
                        if (rd_hit[i]) begin
                            base_nxt = s_base[i]; // [R11]
                            mult_nxt = s_mult[i];
                            num_nxt = s_num[i];
                            den_nxt = s_den[i];
                            ctrl_nxt = s_ctrl[i];
                        end
                    end
                end
                rd_req_nxt = sema_rd_set; // [R11]
                wr_req_nxt = sema_wr_set;
                state_nxt = SVC_IDLE;
            end
            default: state_nxt = SVC_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            base_r <= RST_BASE;
            mult_r <= RST_MULT;
            num_r <= RST_NUM;
            den_r <= RST_DEN;
            ctrl_r <= RST_CTRL;
            mask_r <= RST_MASK;
            wr_req_r <= 1'b0;
            rd_req_r <= 1'b0;
            state_r <= SVC_IDLE;
        end else begin
            base_r <= base_nxt;
            mult_r <= mult_nxt;
            num_r <= num_nxt;
            den_r <= den_nxt;
            ctrl_r <= ctrl_nxt;
            mask_r <= mask_nxt;
            wr_req_r <= wr_req_nxt;
            rd_req_r <= rd_req_nxt;
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // synthesizer slots
    for (genvar g = 0; g < NUM_SYN; g++) begin : g_syn
        svc_synth_slot u_slot (
            .core_clk(core_clk),
            .rst_n(rst_n_r),
            .load(load[g]),
            .base_in(base_r),
            .mult_in(mult_r),
            .num_in(num_r),
            .den_in(den_r),
            .ctrl_in(ctrl_r),
            .base_q(s_base[g]),
            .mult_q(s_mult[g]),
            .num_q(s_num[g]),
            .den_q(s_den[g]),
            .ctrl_q(s_ctrl[g]),
            .loop_sel(s_sel[g]),
            .enable(s_en[g]),
            .vco_freq(s_freq[g])
        );
    end

    ////////////////////////////////////////////////////////////////////
    // read data and registered outputs
    always_comb begin
        rdata_nxt = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                ADR_MASK_LO: rdata_nxt = mask_r[7:0];
                ADR_MASK_HI: rdata_nxt = {6'h00, mask_r[MASK_W-1:8]};
                ADR_SEMA: rdata_nxt = {6'h00, rd_req_r, wr_req_r}; // [R10] [R11]
                ADR_BASE: rdata_nxt = base_r[7:0]; // [R13]
                ADR_BASE + 12'h001: rdata_nxt = base_r[15:8];
                ADR_MULT: rdata_nxt = mult_r[7:0];
                ADR_MULT + 12'h001: rdata_nxt = mult_r[15:8];
                ADR_MULT + 12'h002: rdata_nxt = mult_r[23:16];
                ADR_NUM: rdata_nxt = num_r[7:0];
                ADR_NUM + 12'h001: rdata_nxt = num_r[15:8];
                ADR_DEN: rdata_nxt = den_r[7:0];
                ADR_DEN + 12'h001: rdata_nxt = den_r[15:8];
                ADR_CTRL: rdata_nxt = ctrl_r;
                default: rdata_nxt = 8'h00;
            endcase
        end
        for (int i = 0; i < NUM_SYN; i++) begin
            en_nxt[i] = s_en[i]; // [R9]
            sel_nxt[2*i +: 2] = s_sel[i]; // [R6] [R7]
            freq_nxt[FREQ_W*i +: FREQ_W] = s_freq[i]; // [R1]
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rdata_r <= 8'h00;
            en_r <= '0;
            sel_r <= '0;
            freq_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
            en_r <= en_nxt;
            sel_r <= sel_nxt;
            freq_r <= freq_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign syn_enable = en_r;
    assign syn_loop_sel = sel_r;
    assign syn_vco_freq = freq_r;
endmodule

// file: verification/svc_page_props.sv
// checker for the vco configuration page ports
// assumes it is bound onto svc_page
module svc_page_props
    import svc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire svc_pkg::svc_addr_t reg_addr,
    input wire svc_pkg::svc_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire svc_pkg::svc_byte_t reg_rdata,
    input wire logic [NUM_SYN-1:0] syn_enable,
    input wire logic [2*NUM_SYN-1:0] syn_loop_sel,
    input wire logic [FREQ_W*NUM_SYN-1:0] syn_vco_freq
);
    import svc_pkg::*;

    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    // cycles since the last mailbox request
    always_comb begin
        cnt_nxt = (cnt_r == 4'hf) ? cnt_r : cnt_r + 4'h1;
        if (reg_wr && reg_addr == ADR_SEMA) begin
            cnt_nxt = 4'h0;
        end
    end
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= 4'h0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read answer");
    a_unmapped_zero: assert property (reg_rd && reg_addr > ADR_CTRL |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_ctrl_reserved: assert property (reg_rd && reg_addr == ADR_CTRL |=> (reg_rdata & ~CTRL_KEEP) == 8'h00)
        else $error("control reserved bits not zero");
    a_sema_reserved: assert property (reg_rd && reg_addr == ADR_SEMA |=> reg_rdata[7:2] == 6'h00)
        else $error("semaphore reserved bits not zero");
    a_ctrl_readback: assert property ((reg_wr && reg_addr == ADR_CTRL)
        ##1 (reg_rd && reg_addr == ADR_CTRL) |=> reg_rdata == ($past(reg_wdata, 2) & CTRL_KEEP))
        else $error("control readback wrong");
    a_field_readback: assert property ((reg_wr && reg_addr >= ADR_BASE && reg_addr <= 12'h68d)
        ##1 (reg_rd && reg_addr == $past(reg_addr)) |=> reg_rdata == $past(reg_wdata, 2))
        else $error("frequency term readback wrong");
    a_outs_quiet: assert property ($changed({syn_enable, syn_loop_sel, syn_vco_freq}) |-> cnt_r < 4'ha)
        else $error("synth outputs changed without a commit");
    a_reset_defaults: assert property ($rose(rstn) |-> ##[1:10]
        (syn_enable == 4'hf && syn_vco_freq[63:0] == 64'(RST_BASE) * 64'(RST_MULT)))
        else $error("reset defaults not committed");
endmodule
bind svc_page svc_page_props u_props (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .syn_enable(syn_enable), .syn_loop_sel(syn_loop_sel), .syn_vco_freq(syn_vco_freq));

// file: verification/test_svc_page.sv
// self-checking bench for the vco configuration page
// assumes svc_page and its checker are compiled first
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module test_svc_page;
    timeunit 1ns;
    timeprecision 1ps;
    import svc_pkg::*;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    svc_addr_t reg_addr = 12'h000;
    svc_byte_t reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    svc_byte_t reg_rdata;
    logic [NUM_SYN-1:0] syn_enable;
    logic [2*NUM_SYN-1:0] syn_loop_sel;
    logic [FREQ_W*NUM_SYN-1:0] syn_vco_freq;
    int n_errors = 0;
    int compares = 0;
    logic [15:0] lf = 16'h5db8;
    svc_h_t b, m, n;
    svc_m_t k;
    svc_byte_t c, d;
    svc_h_t bs[NUM_SYN], ms[NUM_SYN], ns[NUM_SYN];
    svc_m_t ks[NUM_SYN];
    svc_byte_t cs[NUM_SYN];
    svc_page uut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .syn_enable(syn_enable),
        .syn_loop_sel(syn_loop_sel), .syn_vco_freq(syn_vco_freq));
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////
    function automatic logic [15:0] rnd();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return lf;
    endfunction
    // expected page byte from the bench copy of the page
    function automatic svc_byte_t pb(input svc_addr_t a);
        logic [71:0] v;
        v = {n, m, k, b};
        if (a == ADR_CTRL) return c & CTRL_KEEP;
        return v[8*(a-ADR_BASE) +: 8];
    endfunction
    task automatic bus(input logic w, input logic r, input svc_addr_t a, input svc_byte_t dt);
        @(posedge core_clk);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= dt;
    endtask
    task automatic rd(input svc_addr_t a, output svc_byte_t v);
        bus(1'b0, 1'b1, a, 8'h00);
        bus(1'b0, 1'b0, a, 8'h00);
        @(negedge core_clk);
        v = reg_rdata;
    endtask
    // optionally write, then read back every frequency-term and control byte
    task automatic page(input logic w);
        svc_addr_t a;
        for (int i = 0; i < 10; i++) begin
            a = (i == 9) ? ADR_CTRL : ADR_BASE + 12'(i);
            if (w) bus(1'b1, 1'b0, a, (a == ADR_CTRL) ? c : pb(a));
            rd(a, d);
            `CHK(d, pb(a))
        end
    endtask
    task automatic commit(input svc_byte_t cmd);
        bus(1'b1, 1'b0, ADR_SEMA, cmd);
        for (int j = 0; j < 20; j++) begin
            rd(ADR_SEMA, d);
            if (d === 8'h00) break;
        end
        `CHK(d, 8'h00)
        repeat (8) @(posedge core_clk);
    endtask
    task automatic sv(input logic [3:0] msk);
        for (int i = 0; i < NUM_SYN; i++) begin
            if (msk[i]) begin
                bs[i] = b;
                ks[i] = k;
                ms[i] = m;
                ns[i] = n;
                cs[i] = c;
            end
        end
    endtask
    task automatic chk_outs();
        logic [2:0] s;
        @(negedge core_clk);
        for (int i = 0; i < NUM_SYN; i++) begin
            s = cs[i][6:4];
            `CHK(syn_enable[i], cs[i][0])
            `CHK(syn_loop_sel[2*i +: 2], (s < NUM_LOOPS) ? s[1:0] : 2'b00)
            `CHK(syn_vco_freq[FREQ_W*i +: FREQ_W], 64'(bs[i]) * 64'(ks[i]) * 64'(ms[i]) / 64'(ns[i]))
        end
    endtask
    task automatic end_of_test();
        $display("n_errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        #(4 * 20000);
        n_errors++;
        end_of_test();
    end
    initial begin
        logic [15:0] t;
        logic [3:0] msk;
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        {b, k, m, n, c} = {RST_BASE, RST_MULT, RST_NUM, RST_DEN, RST_CTRL};
        sv(4'hf);
        repeat (10) @(posedge core_clk);
        chk_outs();
        page(1'b0);
        rd(12'h694, d);
        `CHK(d, 8'h00)
        rd(12'h000, d);
        `CHK(d, 8'h00)
        bus(1'b1, 1'b0, ADR_MASK_HI, 8'h00);
        for (int it = 0; it < 12; it++) begin
            t = rnd();
            msk = (t[11:8] == 4'h0) ? 4'h1 : t[11:8];
            b = rnd();
            k = 24'({rnd(), rnd()});
            m = rnd();
            n = (it == 0) ? 16'h0001 : rnd() | 16'h0001;
            bus(1'b1, 1'b0, ADR_MASK_LO, {4'h0, msk});
            c = t[7:0] & 8'hfe;
            page(1'b1);
            commit(8'h01);
            sv(msk);
            c = t[7:0];
            page(1'b1);
            commit(8'h01);
            sv(msk);
            chk_outs();
            {b, k, m, n, c} = ~{b, k, m, n, c};
            page(1'b1);
            bus(1'b1, 1'b0, ADR_MASK_LO, 8'h01 << t[13:12]);
            commit(8'h02);
            {b, k, m, n, c} = {bs[t[13:12]], ks[t[13:12]], ms[t[13:12]], ns[t[13:12]], cs[t[13:12]]};
            page(1'b0);
        end
        bus(1'b1, 1'b0, ADR_MASK_HI, 8'hff);
        rd(ADR_MASK_HI, d);
        `CHK(d, 8'h03)
        bus(1'b1, 1'b0, ADR_MASK_HI, 8'h00);
        bus(1'b1, 1'b0, ADR_MASK_LO, 8'h03);
        // both request bits with two mask bits: read wins, nothing loads or commits
        commit(8'h03);
        page(1'b0);
        chk_outs();
        end_of_test();
    end
endmodule
